/* File: verilog/acfs_pkg.sv */
package acfs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_FLOW   = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQST  = 8'h0c;
    localparam logic [7:0] REG_IRQMSK = 8'h10;
    localparam logic [7:0] REG_CMD    = 8'h14;
    // control register fields
    localparam int CTRL_TRIGGER_REQUEST_MODE  = 0;
    localparam int CTRL_DOUBLE_BUF = 1;
    localparam int CTRL_AUTO_WAKE  = 2;
    localparam int CTRL_HALT_WAIT  = 3;
    // flow register fields (write 1 to request)
    localparam int FLOW_ABORT   = 0;
    localparam int FLOW_TRIGGER = 1;
    localparam int FLOW_RESTART = 2;
    localparam int FLOW_SWAP    = 3;
    // status fields
    localparam int ST_IDLE      = 4;
    localparam int ST_ACTIVE    = 5;
    localparam int ST_WAIT_TRIGGER_REQUEST = 6;
    // interrupt status bits
    localparam int IRQ_EARLY_TRIGGER_REQUEST    = 0;
    localparam int IRQ_RESTART_ABORT = 1;
    localparam int IRQ_RESTART_ERR   = 2;
    localparam int IRQ_SWAP_ERR      = 3;
    localparam int IRQ_LIST_END      = 4;
    localparam int IRQ_W             = 5;
    // command types
    localparam logic [1:0] CMD_NORMAL  = 2'h0;
    localparam logic [1:0] CMD_END_SEQ = 2'h1;
    localparam logic [1:0] CMD_END_LST = 2'h3;
    // timing
    localparam int LOAD_CYCLES     = 4;
    localparam int TRIGGER_REQUEST_LAT_CYCLES = 2;
    localparam int CMD_CYCLES      = 8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage : acfs_pkg

/* File: verilog/acfs_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module acfs_timer #(
    parameter int W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         start_in,
    input  wire logic [W-1:0] len_in,
    output logic              done_out,
    output logic              busy_out
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_q;
    logic         done_d;

    always_comb begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_in) begin
            cnt_d = len_in;
        end else if (cnt_q != '0) begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_out = done_q;
    assign busy_out = (cnt_q != '0);
endmodule : acfs_timer
`default_nettype wire

/* File: verilog/acfs_sequencer.sv */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - end-of-sequence command idles until next trigger
// - end-of-list type wraps to top, waits
// - each trigger launches next sequence
// - auto restart on wake exit
// - trigger mode restart auto-triggers after load
// - restart mode restart only loads commands
// - trigger during restart sets early-trigger error
// - fixed trigger-to-sampling latency
// - restart with swap bit swaps lists
// - abort stops sequence, clears when idle
// - restart done clears request, starts at top
// - restart while busy auto-aborts, flags error
// - restart plus abort suppresses the restart-abort and restart error flags
module acfs_sequencer #(
    parameter int IDX_W = 4
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [7:0]       addr_in,
    input  wire logic [31:0]      wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    output logic      [31:0]      rdata_out,
    output logic                  irq_out,
    input  wire logic             stop_in,
    input  wire logic             wait_in,
    input  wire logic [1:0]       cmd_type_in,
    output logic      [IDX_W-1:0] cmd_index_out,
    output logic                  sample_start_out,
    output logic                  active_list_out
);
    typedef enum logic [4:0] {
        ACFS_IDLE  = 5'b00001,
        ACFS_LOAD  = 5'b00010,
        ACFS_LAT   = 5'b00100,
        ACFS_CONV  = 5'b01000,
        ACFS_ABORT = 5'b10000
    } acfs_state_t;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    acfs_state_t          st_q, st_d;
    logic [3:0]           ctrl_q, ctrl_d;
    logic                 abort_q, abort_d, trigger_request_q, trigger_request_d;
    logic                 rst_q, rst_d, swap_q, swap_d;
    logic                 both_q, both_d, list_q, list_d;
    logic                 waitend_q, waitend_d, lowp_q, lowp_d;
    localparam int IRQ_W_L = acfs_pkg::IRQ_W;
    logic [IRQ_W_L-1:0]   irqs_q, irqs_d;
    logic [IRQ_W_L-1:0]   mask_q, mask_d;
    logic [IDX_W-1:0]     idx_q, idx_d;
    logic [31:0]          rdata_q, rdata_d;
    logic                 irq_q, sample_q, sample_d;
    logic [1:0]           stop_s, wait_s;
    logic                 tm_start, tm_done, tm_busy;
    logic [3:0]           tm_len;
    logic                 wake_pulse, lowp_now;

    // pins from the power controller are asynchronous
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            stop_s <= 2'h0;
            wait_s <= 2'h0;
        end else begin
            stop_s <= {stop_s[0], stop_in};
            wait_s <= {wait_s[0], wait_in};
        end
    end

    acfs_timer #(.W(4)) u_timer (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .start_in   (tm_start),
        .len_in     (tm_len),
        .done_out   (tm_done),
        .busy_out   (tm_busy)
    );

    assign lowp_now = stop_s[1] | (wait_s[1] & ctrl_q[acfs_pkg::CTRL_HALT_WAIT]);
    assign wake_pulse = lowp_q & ~lowp_now;

    always_comb begin
        logic wflow;
        logic busy;
        wflow      = wr_in && hit(addr_in, acfs_pkg::REG_FLOW);
        busy       = (st_q != ACFS_IDLE);
        st_d       = st_q;
        ctrl_d     = ctrl_q;
        abort_d    = abort_q;
        trigger_request_d     = trigger_request_q;
        rst_d      = rst_q;
        swap_d     = swap_q;
        both_d     = both_q;
        list_d     = list_q;
        waitend_d  = waitend_q;
        lowp_d     = lowp_now;
        irqs_d     = irqs_q;
        mask_d     = mask_q;
        idx_d      = idx_q;
        sample_d   = 1'b0;
        tm_start   = 1'b0;
        tm_len     = acfs_pkg::CNT_ZERO;
        rdata_d    = 32'h0;
        if (wr_in && hit(addr_in, acfs_pkg::REG_CTRL)) begin
            ctrl_d = wdata_in[3:0];
        end
        if (wr_in && hit(addr_in, acfs_pkg::REG_IRQMSK)) begin
            mask_d = wdata_in[IRQ_W_L-1:0];
        end
        // clear-on-read first so any event set below wins
        if (rd_in && hit(addr_in, acfs_pkg::REG_IRQST)) begin
            irqs_d = '0;
        end
        // requests stick until the event completes
        if (wflow) begin
            if (wdata_in[acfs_pkg::FLOW_ABORT]) abort_d = 1'b1;
            if (wdata_in[acfs_pkg::FLOW_RESTART]) begin
                rst_d  = 1'b1;
                both_d = wdata_in[acfs_pkg::FLOW_ABORT] | abort_q;
                if (wdata_in[acfs_pkg::FLOW_SWAP]) swap_d = 1'b1;
                // restart onto a busy core without abort
                if (busy && !wdata_in[acfs_pkg::FLOW_ABORT] && !abort_q) begin
                    abort_d = 1'b1;
                    irqs_d[acfs_pkg::IRQ_RESTART_ABORT] = 1'b1;
                end
                // restart while restart pending, unless with abort
                if (rst_q && !wdata_in[acfs_pkg::FLOW_ABORT]) begin
                    irqs_d[acfs_pkg::IRQ_RESTART_ERR] = 1'b1;
                end
            end else if (wdata_in[acfs_pkg::FLOW_SWAP]) begin
                // swap without restart is an error in both modes
                irqs_d[acfs_pkg::IRQ_SWAP_ERR] = 1'b1;
            end
            if (wdata_in[acfs_pkg::FLOW_TRIGGER]) begin
                // trigger before restart finished
                if (rst_q || (wdata_in[acfs_pkg::FLOW_RESTART]
                        && !ctrl_q[acfs_pkg::CTRL_TRIGGER_REQUEST_MODE])) begin
                    irqs_d[acfs_pkg::IRQ_EARLY_TRIGGER_REQUEST] = 1'b1;
                end else begin
                    trigger_request_d = 1'b1;
                end
            end
        end
        // wake from low power relaunches the list
        if (wake_pulse && ctrl_q[acfs_pkg::CTRL_AUTO_WAKE]) begin
            rst_d = 1'b1;
        end
        unique case (st_q)
            ACFS_IDLE: begin
                if (abort_q) begin
                    abort_d = 1'b0;
                end else if (rst_q) begin
                    st_d     = ACFS_LOAD;
                    tm_start = 1'b1;
                    tm_len   = 4'(acfs_pkg::LOAD_CYCLES);
                end else if (trigger_request_q && !lowp_now) begin
                    trigger_request_d   = 1'b0;
                    st_d     = ACFS_LAT;
                    tm_start = 1'b1;
                    tm_len   = 4'(acfs_pkg::TRIGGER_REQUEST_LAT_CYCLES);
                    if (waitend_q) begin
                        idx_d     = '0;
                        waitend_d = 1'b0;
                    end
                end
            end
            ACFS_LOAD: begin
                if (tm_done) begin
                    st_d      = ACFS_IDLE;
                    rst_d     = 1'b0;
                    both_d    = 1'b0;
                    idx_d     = '0;
                    waitend_d = 1'b0;
                    if (swap_q && ctrl_q[acfs_pkg::CTRL_DOUBLE_BUF]) begin
                        list_d = ~list_q;
                    end
                    swap_d = 1'b0;
                    if (ctrl_q[acfs_pkg::CTRL_TRIGGER_REQUEST_MODE]) begin
                        trigger_request_d = 1'b1;
                    end // restart mode loads only
                end
            end
            ACFS_LAT: begin
                if (abort_q) begin
                    st_d = ACFS_ABORT;
                end else if (tm_done) begin
                    st_d     = ACFS_CONV;
                    sample_d = 1'b1;
                    tm_start = 1'b1;
                    tm_len   = 4'(acfs_pkg::CMD_CYCLES);
                end
            end
            ACFS_CONV: begin
                if (abort_q) begin
                    st_d = ACFS_ABORT;
                end else if (tm_done) begin
                    if (cmd_type_in == acfs_pkg::CMD_END_LST) begin
                        st_d      = ACFS_IDLE;
                        idx_d     = '0;
                        waitend_d = 1'b1;
                        irqs_d[acfs_pkg::IRQ_LIST_END] = 1'b1;
                    end else if (cmd_type_in == acfs_pkg::CMD_END_SEQ) begin
                        st_d  = ACFS_IDLE;
                        idx_d = idx_q + 1'b1;
                    end else begin
                        idx_d    = idx_q + 1'b1;
                        sample_d = 1'b1;
                        tm_start = 1'b1;
                        tm_len   = 4'(acfs_pkg::CMD_CYCLES);
                    end
                end
            end
            ACFS_ABORT: begin
                if (!tm_busy) begin
                    st_d    = ACFS_IDLE;
                    abort_d = 1'b0;
                end
            end
        endcase
        if (rd_in) begin
            if (hit(addr_in, acfs_pkg::REG_CTRL)) rdata_d[3:0] = ctrl_q;
            if (hit(addr_in, acfs_pkg::REG_FLOW)) begin
                rdata_d[3:0] = {swap_q, rst_q, trigger_request_q, abort_q};
            end
            if (hit(addr_in, acfs_pkg::REG_STATUS)) begin
                rdata_d[IDX_W-1:0]             = idx_q;
                rdata_d[acfs_pkg::ST_IDLE]     = ~busy;
                rdata_d[acfs_pkg::ST_ACTIVE]   = list_q;
                rdata_d[acfs_pkg::ST_WAIT_TRIGGER_REQUEST] = waitend_q;
            end
            if (hit(addr_in, acfs_pkg::REG_IRQST)) rdata_d[IRQ_W_L-1:0] = irqs_q;
            if (hit(addr_in, acfs_pkg::REG_IRQMSK)) rdata_d[IRQ_W_L-1:0] = mask_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st_q      <= ACFS_IDLE;
            ctrl_q    <= 4'h0;
            abort_q   <= 1'b0;
            trigger_request_q    <= 1'b0;
            rst_q     <= 1'b0;
            swap_q    <= 1'b0;
            both_q    <= 1'b0;
            list_q    <= 1'b0;
            waitend_q <= 1'b0;
            lowp_q    <= 1'b0;
            irqs_q    <= '0;
            mask_q    <= '0;
            idx_q     <= '0;
            rdata_q   <= 32'h0;
            irq_q     <= 1'b0;
            sample_q  <= 1'b0;
        end else begin
            st_q      <= st_d;
            ctrl_q    <= ctrl_d;
            abort_q   <= abort_d;
            trigger_request_q    <= trigger_request_d;
            rst_q     <= rst_d;
            swap_q    <= swap_d;
            both_q    <= both_d;
            list_q    <= list_d;
            waitend_q <= waitend_d;
            lowp_q    <= lowp_d;
            irqs_q    <= irqs_d;
            mask_q    <= mask_d;
            idx_q     <= idx_d;
            rdata_q   <= rdata_d;
            irq_q     <= |(irqs_d & mask_d);
            sample_q  <= sample_d;
        end
    end

    assign rdata_out        = rdata_q;
    assign irq_out          = irq_q;
    assign cmd_index_out    = idx_q;
    assign sample_start_out = sample_q;
    assign active_list_out  = list_q;

    restart_clears_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_q == ACFS_LOAD && tm_done) |=> !rst_q && idx_q == '0)
        else $error("restart request not cleared after load");
    trigger_request_mode_auto_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_q == ACFS_LOAD && tm_done && ctrl_q[0]) |=> trigger_request_q)
        else $error("trigger mode restart did not trigger");
    restart_only_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_q == ACFS_LOAD && tm_done && !ctrl_q[0] && !trigger_request_q) |=> !trigger_request_q)
        else $error("restart mode generated a trigger");
    fixed_latency_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (sample_q && $past(st_q) == ACFS_LAT)
        |-> $past(st_q, 3) == ACFS_LAT && $past(st_q, 4) == ACFS_IDLE)
        else $error("trigger to sample latency wrong");
    early_trigger_request_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && addr_in == 8'h04 && wdata_in[1] && rst_q)
        |=> irqs_q[0] && !trigger_request_q)
        else $error("early trigger not flagged");
    busy_abort_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (wr_in && addr_in == 8'h04 && wdata_in[2] && !wdata_in[0]
         && !abort_q && st_q != ACFS_IDLE) |=> abort_q && irqs_q[1])
        else $error("busy restart did not auto abort");
    swap_flip_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_q == ACFS_LOAD && tm_done && swap_q && ctrl_q[1])
        |=> list_q != $past(list_q))
        else $error("list swap missing");
    list_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (st_q == ACFS_CONV && tm_done && !abort_q && cmd_type_in == 2'h3)
        |=> st_q == ACFS_IDLE && waitend_q && idx_q == '0)
        else $error("end of list did not hold");
    abort_done_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        $fell(abort_q) |-> st_q == ACFS_IDLE)
        else $error("abort cleared while busy");
endmodule : acfs_sequencer
`default_nettype wire

/* File: tb/acfs_cmd_list_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side command store: list 0 holds two one-command sequences,
// list 1 one two-command sequence that ends the list
module acfs_cmd_list_model (
    input  wire logic [3:0] index_in,
    input  wire logic       list_in,
    output logic      [1:0] type_out
);
    always_comb begin
        // past the end the list still reads end-of-list, never garbage
        type_out = acfs_pkg::CMD_END_LST;
        if (list_in) begin
            if (index_in == 4'h0) type_out = acfs_pkg::CMD_NORMAL;
        end else if (index_in == 4'h0) begin
            type_out = acfs_pkg::CMD_END_SEQ;
        end
    end
endmodule : acfs_cmd_list_model
`default_nettype wire

/* File: tb/acfs_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module acfs_sequencer_bench;
    localparam logic [31:0] F_ABT = 32'h1 << acfs_pkg::FLOW_ABORT;
    localparam logic [31:0] F_TRG = 32'h1 << acfs_pkg::FLOW_TRIGGER;
    localparam logic [31:0] F_RST = 32'h1 << acfs_pkg::FLOW_RESTART;
    localparam logic [31:0] F_SWP = 32'h1 << acfs_pkg::FLOW_SWAP;
    localparam logic [31:0] C_TRG = 32'h1 << acfs_pkg::CTRL_TRIGGER_REQUEST_MODE;
    localparam logic [31:0] C_DBL = 32'h1 << acfs_pkg::CTRL_DOUBLE_BUF;
    localparam logic [31:0] C_WAK = 32'h1 << acfs_pkg::CTRL_AUTO_WAKE;
    localparam logic [31:0] C_HLT = 32'h1 << acfs_pkg::CTRL_HALT_WAIT;
    localparam logic [7:0]  A_FLW = acfs_pkg::REG_FLOW;
    localparam logic [7:0]  A_IRQ = acfs_pkg::REG_IRQST;
    logic        clk_in     = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  addr_in    = 8'h00;
    logic [31:0] wdata_in   = 32'h0;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic        stop_in    = 1'b0;
    logic        wait_in    = 1'b0;
    logic [31:0] rdata_out;
    logic        irq_out;
    logic        sample_start_out;
    logic        active_list_out;
    logic [1:0]  cmd_type_in;
    logic [3:0]  cmd_index_out;
    logic [31:0] rv;
    int fails = 0, checks_done = 0, starts = 0, cyc = 0, last_st = 0;
    int base = 0, t0 = 0, lat1 = 0;
    always #4 clk_in = ~clk_in;
    acfs_sequencer #(.IDX_W(4)) dut_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .irq_out(irq_out), .stop_in(stop_in),
        .wait_in(wait_in), .cmd_type_in(cmd_type_in),
        .cmd_index_out(cmd_index_out), .sample_start_out(sample_start_out),
        .active_list_out(active_list_out));
    acfs_cmd_list_model list_u (.index_in(cmd_index_out),
        .list_in(active_list_out), .type_out(cmd_type_in));
    // sampling-phase pulses are one cycle, so count them continuously
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (sample_start_out === 1'b1) begin
            starts <= starts + 1;
            last_st <= cyc;
        end
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : rd
    task automatic wait_start(int n);
        for (int i = 0; i < 200 && starts < base + n; i++) @(posedge clk_in);
        #1;
        chk("start count", 32'(base + n), 32'(starts));
    endtask : wait_start
    task automatic wait_idle();
        rv = 32'h0;
        for (int i = 0; i < 100 && rv[acfs_pkg::ST_IDLE] !== 1'b1; i++)
            rd(acfs_pkg::REG_STATUS, rv);
        chk("idle", 32'h1, 32'(rv[acfs_pkg::ST_IDLE]));
    endtask : wait_idle
    task automatic wait_flow(logic [31:0] m);
        rv = m;
        for (int i = 0; i < 60 && (rv & m) !== 32'h0; i++) rd(A_FLW, rv);
        chk("flow clear", 32'h0, rv & m);
    endtask : wait_flow
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (30000) @(posedge clk_in);
        fails++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        wr(8'h20, 32'hffffffff);
        rd(8'h20, rv);
        chk("unmapped", 32'h0, rv);
        rd(acfs_pkg::REG_CTRL, rv);
        chk("ctrl reset", 32'h0, rv);
        $display("end: register access");
        wr(acfs_pkg::REG_CTRL, C_TRG);
        wr(A_FLW, F_RST);
        rd(A_FLW, rv);
        chk("restart pending", F_RST, rv & F_RST);
        wait_start(1);
        wait_idle();
        chk("one sequence", 32'(base + 1), 32'(starts));
        wr(A_FLW, F_TRG);
        t0 = cyc;
        wait_start(2);
        lat1 = last_st - t0;
        wait_idle();
        rd(acfs_pkg::REG_STATUS, rv);
        chk("wrap index", 32'h0, 32'(rv[3:0]));
        chk("wait flag", 32'h1, 32'(rv[acfs_pkg::ST_WAIT_TRIGGER_REQUEST]));
        rd(A_IRQ, rv);
        chk("list end", 32'h1, 32'(rv[acfs_pkg::IRQ_LIST_END]));
        wr(A_FLW, F_TRG);
        t0 = cyc;
        wait_start(3);
        chk("latency", 32'(lat1), 32'(last_st - t0));
        chk("from top", 32'h0, 32'(cmd_index_out));
        wait_idle();
        $display("end: trigger mode");
        wr(acfs_pkg::REG_CTRL, 32'h0);
        base = starts;
        wr(A_FLW, F_RST);
        wait_flow(F_RST);
        repeat (20) @(posedge clk_in);
        #1;
        chk("no auto trigger", 32'(base), 32'(starts));
        wr(A_FLW, F_TRG);
        wait_start(1);
        chk("top of list", 32'h0, 32'(cmd_index_out));
        wait_idle();
        $display("end: restart mode");
        wr(acfs_pkg::REG_CTRL, C_TRG);
        base = starts;
        wr(A_FLW, F_RST);
        wait_start(1);
        wr(A_FLW, F_RST);
        rd(A_IRQ, rv);
        chk("restart abort", 32'h1, 32'(rv[acfs_pkg::IRQ_RESTART_ABORT]));
        wait_start(2);
        wr(A_FLW, F_RST | F_ABT);
        rd(A_IRQ, rv);
        chk("no error flags", 32'h0, 32'(rv[2:1]));
        wait_start(3);
        wr(A_FLW, F_RST | F_ABT);
        wr(A_FLW, F_RST);
        rd(A_IRQ, rv);
        chk("restart error", 32'h1, 32'(rv[2]));
        wait_start(4);
        wr(A_FLW, F_ABT);
        wait_flow(F_ABT);
        rd(acfs_pkg::REG_STATUS, rv);
        chk("aborted idle", 32'h1, 32'(rv[acfs_pkg::ST_IDLE]));
        $display("end: abort");
        wr(acfs_pkg::REG_CTRL, C_TRG | C_DBL);
        base = starts;
        wr(A_FLW, F_RST | F_SWP);
        wait_start(1);
        chk("list swapped", 32'h1, 32'(active_list_out));
        wait_idle();
        wr(A_FLW, F_SWP);
        rd(A_IRQ, rv);
        chk("swap error", 32'h1, 32'(rv[acfs_pkg::IRQ_SWAP_ERR]));
        wr(acfs_pkg::REG_CTRL, C_DBL);
        wr(A_FLW, F_RST | F_ABT | F_SWP);
        wait_flow(F_RST | F_ABT | F_SWP);
        rd(A_IRQ, rv);
        chk("swap suppress", 32'h0, 32'(rv[3:2]));
        $display("end: list swap");
        wr(acfs_pkg::REG_CTRL, C_TRG | C_WAK);
        base = starts;
        stop_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        stop_in <= 1'b0;
        wait_start(1);
        wait_idle();
        wr(acfs_pkg::REG_CTRL, C_TRG | C_WAK);
        base = starts;
        wait_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        wait_in <= 1'b0;
        repeat (60) @(posedge clk_in);
        #1;
        chk("wait no halt", 32'(base), 32'(starts));
        wr(acfs_pkg::REG_CTRL, C_TRG | C_WAK | C_HLT);
        wait_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        wait_in <= 1'b0;
        wait_start(1);
        wait_idle();
        $display("end: wake");
        wr(acfs_pkg::REG_CTRL, 32'h0);
        rd(A_IRQ, rv);
        wr(acfs_pkg::REG_IRQMSK, 32'h1f);
        wr(A_FLW, F_RST);
        wr(A_FLW, F_TRG);
        repeat (3) @(posedge clk_in);
        #1;
        chk("irq raised", 32'h1, 32'(irq_out));
        rd(A_IRQ, rv);
        chk("early trigger", 32'h1, 32'(rv[acfs_pkg::IRQ_EARLY_TRIGGER_REQUEST]));
        repeat (2) @(posedge clk_in);
        #1;
        chk("irq cleared", 32'h0, 32'(irq_out));
        $display("end: early trigger");
        wrap_up();
    end
endmodule : acfs_sequencer_bench
`default_nettype wire
